// ### hdl/smd_pkg.sv
package smd_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int LINK_HALF_NS  = 200;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS / CLK_PERIOD_NS < 2) ? 2 : LINK_HALF_NS / CLK_PERIOD_NS;
	localparam logic [2:0] LINK_HALF_LOAD = 3'(LINK_HALF_CYC - 1);
	localparam logic [2:0] LINK_DATA_SLOT = 3'(LINK_HALF_CYC - 2);
	localparam logic       PIN_IDLE       = 1'b1;

	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam logic [1:0] ADDR_FIXED     = 2'b11;
	localparam logic [7:0] OP_LOAD_PARAMS = 8'h89;
	localparam logic [7:0] OP_BURN_FUSE   = 8'h90;
	localparam logic [7:0] OP_MOVE        = 8'h8b;
	localparam logic [7:0] OP_HALT        = 8'h8f;
	localparam logic [7:0] OP_PARK        = 8'h84;
	localparam logic [7:0] OP_REF_SEARCH  = 8'h88;
	localparam logic [7:0] OP_STATUS_A    = 8'h81;
	localparam logic [7:0] OP_STATUS_B    = 8'hfc;
	localparam logic [7:0] FILLER         = 8'hff;
	localparam logic [4:0] FUSE_IDX_PAD   = 5'h1f;
	localparam logic [3:0] LEN_PARAMS     = 4'h9;
	localparam logic [3:0] LEN_FUSE       = 4'h6;
	localparam logic [3:0] LEN_MOVE       = 4'h6;
	localparam logic [3:0] LEN_SHORT      = 4'h2;
	localparam logic [3:0] LEN_REF        = 4'h9;
	localparam int         FRAME_BYTES    = 9;
	localparam int         PROFILE_BIT    = 4;
	localparam int         MSTEP_LSB      = 2;

	// ------------------------------------------------------------
	// device state
	// ------------------------------------------------------------
	localparam logic [10:0] PARK_DISABLED  = 11'h400;
	localparam logic [10:0] PARK_RST       = 11'h000;
	localparam logic [3:0]  NIBBLE_RST     = 4'h0;
	localparam logic [15:0] POS_RST        = 16'h0000;
	localparam logic [7:0]  FUSE_RST       = 8'h00;
	localparam int          FUSE_WORDS     = 8;
	localparam logic [2:0]  ADDR_FUSE_WORD = 3'h0;
	localparam int          ADDR_FUSE_LSB  = 0;

	// ------------------------------------------------------------
	// host registers
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STAT    = 8'h04;
	localparam logic [7:0] REG_MASK    = 8'h08;
	localparam logic [7:0] REG_TX_BASE = 8'h40;
	localparam logic [7:0] REG_RX_BASE = 8'h80;
	localparam int         TX_DEPTH    = 10;
	localparam int         RX_DEPTH    = 2;
	localparam int         EV_DONE     = 0;
	localparam int         EV_RX       = 1;
	localparam int         EV_W        = 2;

	typedef enum logic [2:0]
	{
		H_IDLE  = 3'b000,
		H_START = 3'b001,
		H_LOW   = 3'b011,
		H_HIGH  = 3'b010,
		H_STOP1 = 3'b110,
		H_STOP2 = 3'b111
	} smd_host_state_t;

	typedef enum logic [1:0]
	{
		REF_IDLE   = 2'b00,
		REF_FIRST  = 2'b01,
		REF_SECOND = 2'b11
	} smd_ref_state_t;
endpackage : smd_pkg

// ### hdl/smd_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface smd_link_if;
	logic scl;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic sda;

	// open-drain wire with pull-up
	assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

	modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
	modport dev  (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface : smd_link_if
`default_nettype wire

// ### hdl/smd_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module smd_pin_sync
	import smd_pkg::*;
(
	// system
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	// pin
	input  wire logic i_pin,
	// result
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic meta_q;
	logic lvl_q;
	logic prev_q;

	// reset to idle level so release does not fake an edge
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_q <= PIN_IDLE;
			lvl_q  <= PIN_IDLE;
			prev_q <= PIN_IDLE;
		end
		else if (i_ce)
		begin
			meta_q <= i_pin;
			lvl_q  <= meta_q;
			prev_q <= lvl_q;
		end
	end

	assign o_level = lvl_q;
	assign o_rise  = lvl_q && !prev_q;
	assign o_fall  = !lvl_q && prev_q;
endmodule : smd_pin_sync
`default_nettype wire

// ### hdl/smd_device.sv
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module smd_device
(
	// system
	input  wire logic                 I_CLK,
	input  wire logic                 I_RST_N,
	input  wire logic                 I_CE,
	// link
	smd_link_if.dev                   LINK,
	// environment
	input  wire logic                 i_ADDR_PIN,
	input  wire logic                 i_THERMAL,
	input  wire logic                 i_UNDERVOLT,
	input  wire logic                 i_LOST_STEPS,
	input  wire logic                 i_COIL_FAULT,
	input  wire logic                 i_MOTION_DONE,
	input  wire logic [15:0]          i_CURRENT_POS,
	// motion parameters
	output logic [3:0]                o_DRIVE_CURRENT,
	output logic [3:0]                o_STANDSTILL_CURRENT,
	output logic [3:0]                o_TOP_SPEED,
	output logic [3:0]                o_FLOOR_SPEED,
	output logic [3:0]                o_RAMP_RATE,
	output logic                      o_RAMP_PROFILE,
	output logic [1:0]                o_MICROSTEP,
	output logic                      o_DIR_INVERT,
	output logic [10:0]               o_PARK_POS,
	// motion requests
	output logic [15:0]               o_TARGET,
	output logic [15:0]               o_REF_TARGET2,
	output logic                      o_MOVE_REQ,
	output logic                      o_HALT_REQ,
	output logic                      o_PARK_REQ,
	output logic                      o_REF_START,
	output logic                      o_POS_CLEAR,
	output logic                      o_SHUTDOWN,
	// fuse image
	output logic [8*smd_pkg::FUSE_WORDS-1:0] o_FUSE_IMAGE
);
	import smd_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic sck;
	logic sck_rise;
	logic sck_fall;
	logic sd;
	logic sd_rise;
	logic sd_fall;
	logic apin_lvl;

	smd_pin_sync u_sck (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_ce(I_CE), .i_pin(LINK.scl),
		.o_level(sck), .o_rise(sck_rise), .o_fall(sck_fall));
	smd_pin_sync u_sd (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_ce(I_CE), .i_pin(LINK.sda),
		.o_level(sd), .o_rise(sd_rise), .o_fall(sd_fall));
	smd_pin_sync u_apin (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_ce(I_CE), .i_pin(i_ADDR_PIN),
		.o_level(apin_lvl), .o_rise(), .o_fall());

	// ------------------------------------------------------------
	// frame receiver
	// ------------------------------------------------------------
	logic           in_frame_q;
	logic           skip_q;
	logic           rd_q;
	logic [2:0]     bit_q;
	logic [3:0]     bcnt_q;
	logic [7:0]     shift_q;
	logic [7:0]     frm_q [0:FRAME_BYTES-1];
	logic [7:0]     fuse_q [0:FUSE_WORDS-1];
	logic [15:0]    tx_q;
	logic [7:0]     own_addr;
	logic [7:0]     byte_val;
	logic           start_ev;
	logic           stop_ev;
	logic           byte_done;

	assign start_ev  = sd_fall && sck;
	assign stop_ev   = sd_rise && sck;
	assign byte_done = in_frame_q && !rd_q && sck_rise && (bit_q == 3'h7);
	assign byte_val  = {shift_q[6:0], sd};
	assign own_addr  = {ADDR_FIXED, fuse_q[ADDR_FUSE_WORD][ADDR_FUSE_LSB +: 4], apin_lvl, 1'b0};

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			in_frame_q <= 1'b0;
			skip_q     <= 1'b0;
			bit_q      <= 3'h0;
			bcnt_q     <= 4'h0;
			shift_q    <= 8'h00;
		end
		else if (I_CE)
		begin
			if (start_ev)
			begin
				in_frame_q <= 1'b1;
				skip_q     <= 1'b0;
				bit_q      <= 3'h0;
				bcnt_q     <= 4'h0;
			end
			else if (stop_ev)
				in_frame_q <= 1'b0;
			else if (in_frame_q && !rd_q && sck_rise)
			begin
				shift_q <= byte_val;
				bit_q   <= bit_q + 3'h1;
				if (byte_done && bcnt_q != 4'hf)
					bcnt_q <= bcnt_q + 4'h1;
				if (byte_done && bcnt_q == 4'h0 && byte_val != own_addr)
					skip_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			for (int i = 0; i < FRAME_BYTES; i++)
				frm_q[i] <= 8'h00;
		end
		else if (I_CE && byte_done && bcnt_q < 4'(FRAME_BYTES))
			frm_q[bcnt_q] <= byte_val;
	end

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic exec;
	logic fill_ok;
	logic any_fault;
	logic motion_ok;
	logic shut_q;
	logic therm_q;
	logic stat_a_hit;
	logic stat_b_hit;
	logic do_params;
	logic do_fuse;
	logic do_move;
	logic do_halt;
	logic do_park;
	logic do_ref;
	smd_ref_state_t ref_q;

	// unknown opcodes match none of these; wrong lengths match none but the two status hits, decoded before the length is known
	assign exec       = stop_ev && in_frame_q && !skip_q;
	assign fill_ok    = (frm_q[2] == FILLER) && (frm_q[3] == FILLER);
	assign do_params  = exec && frm_q[1] == OP_LOAD_PARAMS && bcnt_q == LEN_PARAMS && fill_ok;
	assign do_fuse    = exec && frm_q[1] == OP_BURN_FUSE && bcnt_q == LEN_FUSE && fill_ok
		&& frm_q[4][7:3] == FUSE_IDX_PAD;
	assign do_move    = exec && frm_q[1] == OP_MOVE && bcnt_q == LEN_MOVE && fill_ok;
	assign do_halt    = exec && frm_q[1] == OP_HALT && bcnt_q == LEN_SHORT;
	assign do_park    = exec && frm_q[1] == OP_PARK && bcnt_q == LEN_SHORT;
	assign do_ref     = exec && frm_q[1] == OP_REF_SEARCH && bcnt_q == LEN_REF && fill_ok;
	assign stat_a_hit = byte_done && !skip_q && bcnt_q == 4'h1 && byte_val == OP_STATUS_A;
	assign stat_b_hit = byte_done && !skip_q && bcnt_q == 4'h1 && byte_val == OP_STATUS_B;
	assign any_fault  = i_THERMAL || i_UNDERVOLT || i_LOST_STEPS || i_COIL_FAULT;
	assign motion_ok  = !shut_q && !any_fault;

	// starts shut down; a fault re-enters and wins over the release
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			shut_q  <= 1'b1;
			therm_q <= 1'b0;
		end
		else if (I_CE)
		begin
			therm_q <= i_THERMAL;
			if (any_fault)
				shut_q <= 1'b1;
			else if (stat_a_hit)
				shut_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// status answer, open drain, changed while the link clock is low
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			rd_q          <= 1'b0;
			tx_q          <= 16'hffff;
			LINK.d_sda_oe <= 1'b0;
		end
		else if (I_CE)
		begin
			if (start_ev || stop_ev)
			begin
				rd_q          <= 1'b0;
				LINK.d_sda_oe <= 1'b0;
			end
			else if (stat_a_hit)
			begin
				rd_q <= 1'b1;
				tx_q <= {i_THERMAL, i_UNDERVOLT, i_LOST_STEPS, i_COIL_FAULT, shut_q, 3'h0, 8'hff};
			end
			else if (stat_b_hit)
			begin
				rd_q <= 1'b1;
				tx_q <= i_CURRENT_POS;
			end
			else if (rd_q && sck_fall)
			begin
				LINK.d_sda_oe <= !tx_q[15];
				tx_q          <= {tx_q[14:0], 1'b1};
			end
		end
	end

	assign LINK.d_sda_o = 1'b0;

	// ------------------------------------------------------------
	// parameter RAM and fuses
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			o_DRIVE_CURRENT      <= NIBBLE_RST;
			o_STANDSTILL_CURRENT <= NIBBLE_RST;
			o_TOP_SPEED          <= NIBBLE_RST;
			o_FLOOR_SPEED        <= NIBBLE_RST;
			o_RAMP_RATE          <= NIBBLE_RST;
			o_RAMP_PROFILE       <= 1'b0;
			o_MICROSTEP          <= 2'h0;
			o_DIR_INVERT         <= 1'b0;
			o_PARK_POS           <= PARK_RST;
		end
		else if (I_CE && do_params)
		begin
			o_DRIVE_CURRENT      <= frm_q[4][7:4];
			o_STANDSTILL_CURRENT <= frm_q[4][3:0];
			o_TOP_SPEED          <= frm_q[5][7:4];
			o_FLOOR_SPEED        <= frm_q[5][3:0];
			o_PARK_POS           <= {frm_q[6][7:5], frm_q[7]};
			o_DIR_INVERT         <= frm_q[6][4];
			o_RAMP_RATE          <= frm_q[6][3:0];
			o_RAMP_PROFILE       <= frm_q[8][PROFILE_BIT];
			o_MICROSTEP          <= frm_q[8][MSTEP_LSB +: 2];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			for (int i = 0; i < FUSE_WORDS; i++)
				fuse_q[i] <= FUSE_RST;
		end
		else if (I_CE && do_fuse)
			fuse_q[frm_q[4][2:0]] <= fuse_q[frm_q[4][2:0]] | frm_q[5];
	end

	for (genvar g = 0; g < FUSE_WORDS; g++)
	begin : g_fuse
		assign o_FUSE_IMAGE[8*g +: 8] = fuse_q[g];
	end

	// ------------------------------------------------------------
	// motion requests
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			o_TARGET      <= POS_RST;
			o_REF_TARGET2 <= POS_RST;
			o_MOVE_REQ    <= 1'b0;
			o_HALT_REQ    <= 1'b0;
			o_PARK_REQ    <= 1'b0;
			o_REF_START   <= 1'b0;
			o_POS_CLEAR   <= 1'b0;
			ref_q         <= REF_IDLE;
		end
		else if (I_CE)
		begin
			o_MOVE_REQ  <= do_move && motion_ok;
			o_HALT_REQ  <= do_halt || (i_THERMAL && !therm_q);
			o_PARK_REQ  <= do_park && o_PARK_POS != PARK_DISABLED;
			o_REF_START <= do_ref && motion_ok;
			o_POS_CLEAR <= (ref_q == REF_SECOND) && i_MOTION_DONE;
			if (do_move && motion_ok)
				o_TARGET <= {frm_q[4], frm_q[5]};
			else if (do_ref && motion_ok)
			begin
				o_TARGET      <= {frm_q[5], frm_q[6]};
				o_REF_TARGET2 <= {frm_q[7], frm_q[8]};
			end
			unique case (ref_q)
				REF_IDLE:   if (do_ref && motion_ok) ref_q <= REF_FIRST;
				REF_FIRST:  if (i_MOTION_DONE) ref_q <= REF_SECOND;
				REF_SECOND: if (i_MOTION_DONE) ref_q <= REF_IDLE;
				default:    ref_q <= REF_IDLE;
			endcase
		end
	end

	assign o_SHUTDOWN = shut_q;
endmodule : smd_device
`default_nettype wire

// ### hdl/smd_host.sv
`timescale 1ns/1ns
`default_nettype none
module smd_host
(
	// system
	input  wire logic       I_CLK,
	input  wire logic       I_RST_N,
	input  wire logic       I_CE,
	// link
	smd_link_if.host        LINK,
	// register port
	input  wire logic [7:0] i_ADDR,
	input  wire logic [7:0] i_WDATA,
	input  wire logic       i_WR,
	input  wire logic       i_RD,
	output logic [7:0]      o_RDATA,
	output logic            o_IRQ
);
	import smd_pkg::*;

	logic sd;

	smd_pin_sync u_sd (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_ce(I_CE), .i_pin(LINK.sda),
		.o_level(sd), .o_rise(), .o_fall());

	// ------------------------------------------------------------
	// frame engine
	// ------------------------------------------------------------
	smd_host_state_t state_q;
	logic [2:0]      cnt_q;
	logic [2:0]      bit_q;
	logic [3:0]      byte_q;
	logic [3:0]      txn_q;
	logic [1:0]      rxn_q;
	logic [7:0]      sh_q;
	logic [7:0]      tx_q [0:TX_DEPTH-1];
	logic [7:0]      rx_q [0:RX_DEPTH-1];
	logic [EV_W-1:0] stat_q;
	logic [EV_W-1:0] mask_q;
	logic            tick;
	logic            go;
	logic            last_byte;
	logic            in_tx;
	logic            byte_end;
	logic            done_ev;
	logic [3:0]      nxt_byte;
	logic [3:0]      rx_off;

	assign tick      = cnt_q == 3'h0;
	assign go        = i_WR && i_ADDR == REG_CTRL && state_q == H_IDLE && i_WDATA[3:0] != 4'h0
		&& i_WDATA[3:0] <= 4'(TX_DEPTH);
	assign last_byte = byte_q == txn_q + {2'h0, rxn_q} - 4'h1;
	assign in_tx     = byte_q < txn_q;
	assign nxt_byte  = byte_q + 4'h1;
	assign rx_off    = byte_q - txn_q;
	assign byte_end  = state_q == H_HIGH && tick && bit_q == 3'h7;
	assign done_ev   = state_q == H_STOP2 && tick;

	// link clock made here by dividing the system clock
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			state_q       <= H_IDLE;
			cnt_q         <= LINK_HALF_LOAD;
			bit_q         <= 3'h0;
			byte_q        <= 4'h0;
			txn_q         <= 4'h0;
			rxn_q         <= 2'h0;
			sh_q          <= 8'h00;
			LINK.scl      <= 1'b1;
			LINK.h_sda_oe <= 1'b0;
		end
		else if (I_CE)
		begin
			cnt_q <= tick ? LINK_HALF_LOAD : cnt_q - 3'h1;
			unique case (state_q)
				H_IDLE:
				begin
					cnt_q <= LINK_HALF_LOAD;
					if (go)
					begin
						txn_q         <= i_WDATA[3:0];
						rxn_q         <= i_WDATA[5:4];
						byte_q        <= 4'h0;
						bit_q         <= 3'h0;
						sh_q          <= tx_q[0];
						LINK.h_sda_oe <= 1'b1;
						state_q       <= H_START;
					end
				end
				H_START:
					if (tick)
					begin
						LINK.scl <= 1'b0;
						state_q  <= H_LOW;
					end
				H_LOW:
				begin
					// data moves two cycles after the fall, never beside it
					if (cnt_q == LINK_DATA_SLOT)
						LINK.h_sda_oe <= in_tx && !sh_q[7];
					if (tick)
					begin
						LINK.scl <= 1'b1;
						state_q  <= H_HIGH;
					end
				end
				H_HIGH:
					if (tick)
					begin
						LINK.scl <= 1'b0;
						bit_q    <= bit_q + 3'h1;
						sh_q     <= {sh_q[6:0], sd};
						state_q  <= H_LOW;
						if (bit_q == 3'h7)
						begin
							byte_q <= nxt_byte;
							if (last_byte)
								state_q <= H_STOP1;
							else if (nxt_byte < txn_q)
								sh_q <= tx_q[nxt_byte];
						end
					end
				H_STOP1:
				begin
					// one slot later, so a device still sending its last bit has let go
					if (cnt_q == LINK_DATA_SLOT - 3'h1)
						LINK.h_sda_oe <= 1'b1;
					if (tick)
					begin
						LINK.scl <= 1'b1;
						state_q  <= H_STOP2;
					end
				end
				H_STOP2:
					if (tick)
					begin
						LINK.h_sda_oe <= 1'b0;
						state_q       <= H_IDLE;
					end
				default:
					state_q <= H_IDLE;
			endcase
		end
	end

	assign LINK.h_sda_o = 1'b0;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			for (int i = 0; i < TX_DEPTH; i++)
				tx_q[i] <= 8'h00;
			mask_q <= '0;
		end
		else if (I_CE && i_WR)
		begin
			if (i_ADDR == REG_MASK)
				mask_q <= i_WDATA[EV_W-1:0];
			else if (i_ADDR[7:6] == REG_TX_BASE[7:6] && i_ADDR[1:0] == 2'h0 && i_ADDR[5:2] < 4'(TX_DEPTH))
				tx_q[i_ADDR[5:2]] <= i_WDATA;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			for (int i = 0; i < RX_DEPTH; i++)
				rx_q[i] <= 8'h00;
		end
		else if (I_CE && byte_end && !in_tx)
			rx_q[rx_off[0]] <= {sh_q[6:0], sd};
	end

	// a new event wins over the clearing read
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			stat_q <= '0;
			o_IRQ  <= 1'b0;
		end
		else if (I_CE)
		begin
			stat_q[EV_DONE] <= (stat_q[EV_DONE] && !(i_RD && i_ADDR == REG_STAT)) || done_ev;
			stat_q[EV_RX]   <= (stat_q[EV_RX] && !(i_RD && i_ADDR == REG_STAT)) || (done_ev && rxn_q != 2'h0);
			o_IRQ           <= |(stat_q & mask_q);
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			o_RDATA <= 8'h00;
		else if (I_CE)
		begin
			o_RDATA <= 8'h00;
			if (i_RD)
			begin
				if (i_ADDR == REG_CTRL)
					o_RDATA <= {7'h00, state_q != H_IDLE};
				else if (i_ADDR == REG_STAT)
					o_RDATA <= {6'h00, stat_q};
				else if (i_ADDR == REG_MASK)
					o_RDATA <= {6'h00, mask_q};
				else if (i_ADDR[7:6] == REG_RX_BASE[7:6] && i_ADDR[5:3] == 3'h0 && i_ADDR[1:0] == 2'h0)
					o_RDATA <= rx_q[i_ADDR[2]];
			end
		end
	end
endmodule : smd_host
`default_nettype wire

// ### tb/smd_link_props.sv
`timescale 1ns/1ns
`default_nettype none
module smd_link_props
(
	// system
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// link wires
	input wire logic i_scl,
	input wire logic i_h_sda_o,
	input wire logic i_h_sda_oe,
	input wire logic i_d_sda_o,
	input wire logic i_d_sda_oe,
	input wire logic i_sda
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	logic       scl_q;
	logic       sda_q;
	logic [7:0] bits_q;
	// ------------------------------------------------------------
	// bit count since start, to judge frame length at stop
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			bits_q <= 8'h00;
		end
		else
		begin
			scl_q <= i_scl;
			sda_q <= i_sda;
			if (i_scl && sda_q && !i_sda)
				bits_q <= 8'h00;
			else if (i_scl && !scl_q)
				bits_q <= bits_q + 8'h01;
		end
	end
	// ------------------------------------------------------------
	// wire rules
	// ------------------------------------------------------------
	// the clock rise that opens the stop adds one to the bit count
	a_whole_bytes: assert property ((i_scl && scl_q && !sda_q && i_sda)
		|-> (bits_q[2:0] == 3'h1 && bits_q != 8'h01))
		else $error("stop after a partial byte");
	a_high_half: assert property ($rose(i_scl) |-> i_scl [*4])
		else $error("link clock high half too short");
	a_low_half: assert property ($fell(i_scl) |-> !i_scl [*4])
		else $error("link clock low half too short");
	a_data_steady: assert property ($rose(i_scl) |-> $stable(i_sda) [*3])
		else $error("data moved while clock high");
	a_start_hold: assert property ((i_scl && scl_q && sda_q && !i_sda) |-> i_scl [*3])
		else $error("start not held");
	a_stop_idle: assert property ((i_scl && scl_q && !sda_q && i_sda) |=> (i_scl && i_sda) [*2])
		else $error("link not idle after stop");
	a_dev_on_low: assert property ($rose(i_d_sda_oe) |-> !i_scl)
		else $error("device drives during clock high");
	a_no_fight: assert property (i_d_sda_oe |-> !i_h_sda_oe)
		else $error("both ends drive data");
	a_drain_only: assert property ((i_h_sda_oe || i_d_sda_oe) |-> (!i_sda && !i_h_sda_o && !i_d_sda_o))
		else $error("data line not pulled low");
endmodule : smd_link_props
`default_nettype wire

// ### tb/stepper_motion_command_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none
module stepper_motion_command_decoder_test;
	import smd_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, apin = 1'b1, done = 1'b0;
	logic th = 1'b0, uv = 1'b0, ls = 1'b0, cf = 1'b0, irq, prof, dirv, sd, mv, hl, pq, pc, rs;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
	logic [15:0] pos = 16'hbeef, tg, tg2;
	logic [3:0]  drv, sst, tsp, fsp, rr;
	logic [1:0]  ms;
	logic [10:0] pk;
	logic [63:0] fz;
	int          err_count = 0, checks = 0, mv_n = 0, hl_n = 0, pk_n = 0, pc_n = 0, rs_n = 0;
	always #25 clk = !clk;
	smd_link_if lnk();
	smd_host i_smd_host(.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .LINK(lnk), .i_ADDR(addr),
		.i_WDATA(wdata), .i_WR(wr_s), .i_RD(rd_s), .o_RDATA(rdata), .o_IRQ(irq));
	smd_device i_smd_device(.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .LINK(lnk), .i_ADDR_PIN(apin),
		.i_THERMAL(th), .i_UNDERVOLT(uv), .i_LOST_STEPS(ls), .i_COIL_FAULT(cf), .i_MOTION_DONE(done),
		.i_CURRENT_POS(pos), .o_DRIVE_CURRENT(drv), .o_STANDSTILL_CURRENT(sst), .o_TOP_SPEED(tsp),
		.o_FLOOR_SPEED(fsp), .o_RAMP_RATE(rr), .o_RAMP_PROFILE(prof), .o_MICROSTEP(ms), .o_DIR_INVERT(dirv),
		.o_PARK_POS(pk), .o_TARGET(tg), .o_REF_TARGET2(tg2), .o_MOVE_REQ(mv), .o_HALT_REQ(hl),
		.o_PARK_REQ(pq), .o_REF_START(rs), .o_POS_CLEAR(pc), .o_SHUTDOWN(sd), .o_FUSE_IMAGE(fz));
	smd_link_props i_smd_link_props(.I_CLK(clk), .I_RST_N(rst_n), .i_scl(lnk.scl), .i_h_sda_o(lnk.h_sda_o),
		.i_h_sda_oe(lnk.h_sda_oe), .i_d_sda_o(lnk.d_sda_o), .i_d_sda_oe(lnk.d_sda_oe), .i_sda(lnk.sda));
	// one-cycle request pulses are counted as they pass
	always @(posedge clk)
	begin
		mv_n += int'(mv === 1'b1);
		hl_n += int'(hl === 1'b1);
		pk_n += int'(pq === 1'b1);
		pc_n += int'(pc === 1'b1);
		rs_n += int'(rs === 1'b1);
	end
	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic summarize();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk(32'(rdata), 32'(e));
	endtask : rd
	// frame bytes sit right-aligned in f, first byte highest
	task automatic send(input logic [79:0] f, input int n, input logic [7:0] c, input logic [7:0] st);
		int k;
		for (int i = 0; i < n; i++)
			wr(REG_TX_BASE + 8'(4 * i), f[8 * (n - 1 - i) +: 8]);
		wr(REG_CTRL, c);
		k = 0;
		while (irq !== 1'b1 && k < 4000)
		begin
			@(posedge clk);
			k++;
		end
		if (k == 4000)
		begin
			err_count++;
			summarize();
		end
		wr(REG_MASK, 8'h00);
		rd(REG_MASK, 8'h00);
		chk(32'(irq), 32'h0);
		rd(REG_STAT, st);
		wr(REG_MASK, 8'h01);
		rd(REG_CTRL, 8'h00);
		chk(32'(irq), 32'h0);
		repeat (8) @(posedge clk);
	endtask : send
	task automatic stat_a(input logic [7:0] e);
		send(80'(16'hc281), 2, 8'h12, 8'h03);
		rd(REG_RX_BASE, e);
	endtask : stat_a
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		wr(REG_MASK, 8'h01);
		rd(8'h20, 8'h00);
		send(80'(72'hc289ffff5a3cb7211c), 9, 8'h09, 8'h01);
		chk({drv, sst, tsp, fsp}, 32'h5a3c);
		chk(32'({rr, prof, ms, dirv}), 32'h7f);
		chk({5'h0, pk, 15'h0, |fz}, 32'h05210000);
		send(80'(48'hc28bffff1234), 6, 8'h06, 8'h01);
		chk(32'(mv_n), 32'h0);
		stat_a(8'h08);
		chk(32'(sd), 32'h0);
		send(80'(48'hc28bffff1234), 6, 8'h06, 8'h01);
		chk({tg, 16'(mv_n)}, 32'h12340001);
		for (int i = 0; i < 4; i++)
		begin
			{th, uv, ls, cf} <= 4'h8 >> i;
			send(80'(48'hc28bffff5678), 6, 8'h06, 8'h01);
			chk({tg, 16'(mv_n)}, 32'h12340001);
			stat_a((8'h80 >> i) | 8'h08);
			{th, uv, ls, cf} <= 4'h0;
			stat_a(8'h08);
		end
		chk(32'(hl_n), 32'h1);
		send(80'(16'hc28f), 2, 8'h02, 8'h01);
		send(80'(16'hc284), 2, 8'h02, 8'h01);
		send(80'(72'hc289ffff5a3c80001c), 9, 8'h09, 8'h01);
		send(80'(16'hc284), 2, 8'h02, 8'h01);
		chk({5'h0, pk, 8'(hl_n), 8'(pk_n)}, 32'h04000201);
		send(80'(48'hc290fffff805), 6, 8'h06, 8'h01);
		send(80'(48'hd690fffff80a), 6, 8'h06, 8'h01);
		chk(32'(fz), 32'h0f);
		send(80'(16'hc28f), 2, 8'h02, 8'h01);
		chk(32'(hl_n), 32'h2);
		apin <= 1'b0;
		send(80'(16'hfc8f), 2, 8'h02, 8'h01);
		apin <= 1'b1;
		chk(32'(hl_n), 32'h3);
		send(80'(72'hfe88ffff0001000200), 9, 8'h09, 8'h01);
		chk({tg, tg2}, 32'h01000200);
		chk(32'(rs_n), 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
			repeat (4) @(posedge clk);
			chk(32'(pc_n), 32'(i));
		end
		send(80'(48'hfe8bff001234), 6, 8'h06, 8'h01);
		chk({tg, 16'(mv_n)}, 32'h01000001);
		send(80'(16'hfefc), 2, 8'h22, 8'h03);
		rd(REG_RX_BASE, 8'hbe);
		rd(REG_RX_BASE + 8'h04, 8'hef);
		summarize();
	end
endmodule : stepper_motion_command_decoder_test
`default_nettype wire
